// ===== src/sar_adc_pkg.sv
/*
  Constants and types shared by the successive-approximation conversion sequencer.
  Assumes a single 100 MHz system clock domain.
*/
package sar_adc_pkg;

  // ------------------------------------------------------------------
  // Converter shape
  // ------------------------------------------------------------------
  localparam int unsigned RESULT_BITS    = 12;
  localparam logic [3:0]  MSB_INDEX      = 4'hB;
  localparam logic [1:0]  TRACK_CLOCKS   = 2'h3;
  localparam logic [3:0]  TEMP_CHANNEL   = 4'h8;

  // ------------------------------------------------------------------
  // Values after reset
  // ------------------------------------------------------------------
  localparam logic [3:0]  PAIR_CFG_RESET = 4'h0;
  localparam logic [2:0]  GAIN_RESET     = 3'h0;
  localparam logic [3:0]  CHAN_RESET     = 4'h0;
  localparam logic [4:0]  DIVIDER_RESET  = 5'h1F;

  // ------------------------------------------------------------------
  // Start-mode codes
  // ------------------------------------------------------------------
  localparam logic [1:0]  START_SW       = 2'h0;
  localparam logic [1:0]  START_TIMER3   = 2'h1;
  localparam logic [1:0]  START_PIN      = 2'h2;
  localparam logic [1:0]  START_TIMER2   = 2'h3;

  // ------------------------------------------------------------------
  // One-hot gain selects: bit 0 is 0.5, then 1, 2, 4, 8, 16
  // ------------------------------------------------------------------
  localparam logic [5:0]  GAIN_HALF      = 6'h01;
  localparam logic [5:0]  GAIN_X1        = 6'h02;
  localparam logic [5:0]  GAIN_X2        = 6'h04;
  localparam logic [5:0]  GAIN_X4        = 6'h08;
  localparam logic [5:0]  GAIN_X8        = 6'h10;
  localparam logic [5:0]  GAIN_X16       = 6'h20;

  typedef enum logic [2:0] {
    ST_IDLE    = 3'h1,
    ST_TRACK   = 3'h2,
    ST_CONVERT = 3'h4
  } seq_state_e;

  typedef struct packed {
    logic [3:0] pos;
    logic [3:0] neg;
    logic       diff;
  } mux_sel_s;

endpackage

// ===== src/sar_adc_conversion_sequencer.sv
/*
  Conversion sequencer for a 12-bit successive-approximation converter:
  trigger selection, tracking control, clock divider, bit search, result
  justification and completion flag.
  Assumes all inputs synchronous to i_clock; the analog comparator answers
  on i_cmp_above before each converter clock tick.
*/
`timescale 1ns/1ps
`default_nettype none

// Functional notes
// R01 - Analog parts powered only while enabled
// R02 - Nine channels: eight inputs plus temperature
// R03 - Pairs single-ended or differential, changeable between conversions
// R04 - Pairs single-ended after reset
// R05 - Gain 0.5 to 16, unity after reset
// R06 - Temperature sensor routed through gain stage
// R07 - Converter clock divided from system clock
// R08 - Software keeps rate within 100 ksps
// R09 - Start source chosen by start-mode bits
// R10 - Busy high throughout conversion
// R11 - Busy fall sets done flag, interrupt
// R12 - Result left or right justified
// R13 - Software clears flag, starts, polls, reads
// R14 - Track mode 0: track while idle
// R15 - Track mode 1: three-clock track first
// R16 - Pin mode: track while low, convert rising
// R17 - No tracking in chip standby
// R18 - Start-mode codes 00 01 10 11
// R19 - Gain field encoding per code
// R20 - Converter clock is system over divider+1
// R21 - Done flag cleared only by software
// R22 - Triggers ignored while busy
module sar_adc_conversion_sequencer
  import sar_adc_pkg::*;
(
  input  wire logic        i_clock,
  input  wire logic        i_reset_n,
  input  wire logic        i_conv_enable,
  input  wire logic        i_track_mode_sel,
  input  wire logic        i_start_mode_hi,
  input  wire logic        i_start_mode_lo,
  input  wire logic        i_left_justify,
  input  wire logic        i_irq_enable,
  input  wire logic        i_busy_write,
  input  wire logic        i_done_clear,
  input  wire logic [3:0]  i_pair_config,
  input  wire logic [3:0]  i_channel_select_field,
  input  wire logic [2:0]  i_gain_field,
  input  wire logic [4:0]  i_clock_divider_field,
  input  wire logic        i_timer3_overflow,
  input  wire logic        i_timer2_overflow,
  input  wire logic        i_ext_convert_start,
  input  wire logic        i_chip_standby,
  input  wire logic        i_cmp_above,
  output logic             o_conv_busy,
  output logic             o_conv_done_flag,
  output logic             o_irq,
  output logic             o_analog_on,
  output logic             o_track,
  output logic [11:0]      o_trial_code,
  output mux_sel_s         o_mux_sel,
  output logic [5:0]       o_gain_sel,
  output logic [7:0]       o_result_high,
  output logic [7:0]       o_result_low
);

  // ------------------------------------------------------------------
  // Functions
  // ------------------------------------------------------------------
  function automatic logic [5:0] gain_decode(input logic [2:0] f);
    logic [5:0] g;
    g = GAIN_X1;
    if (f[2:1] == 2'h3) g = GAIN_HALF;                      // R19
    else if (f[2]) g = GAIN_X16;                            // R19
    else if (f[1:0] == 2'h1) g = GAIN_X2;
    else if (f[1:0] == 2'h2) g = GAIN_X4;
    else if (f[1:0] == 2'h3) g = GAIN_X8;
    return g;
  endfunction

  function automatic mux_sel_s mux_decode(input logic [3:0] ch, input logic [3:0] pairs);
    mux_sel_s m;
    m.pos  = ch;
    m.neg  = ch;
    m.diff = 1'b0;
    if (ch[3]) begin
      m.pos = TEMP_CHANNEL;                                 // R02 R06
      m.neg = TEMP_CHANNEL;
    end else if (pairs[ch[2:1]]) begin
      m.pos  = {1'b0, ch[2:1], 1'b0};                       // R03
      m.neg  = {1'b0, ch[2:1], 1'b1};
      m.diff = 1'b1;
    end
    return m;
  endfunction

  // ------------------------------------------------------------------
  // State
  // ------------------------------------------------------------------
  seq_state_e  state_q, state_d;
  logic [4:0]  div_cnt_q, div_cnt_d;
  logic [1:0]  trk_cnt_q, trk_cnt_d;
  logic [3:0]  bit_q, bit_d;
  logic [11:0] code_q, code_d;
  logic        pin_q;
  logic        busy_q, busy_d;
  logic        done_q, done_d;
  logic        irq_q, irq_d;
  logic        on_q, on_d;
  logic        trk_q, trk_d;
  logic [3:0]  pair_q, pair_d;
  logic [3:0]  chan_q, chan_d;
  logic [2:0]  gain_q, gain_d;
  logic [4:0]  div_q, div_d;
  mux_sel_s    mux_q, mux_d;
  logic [5:0]  gsel_q, gsel_d;
  logic [7:0]  rhi_q, rhi_d, rlo_q, rlo_d;

  logic [1:0]  mode;
  logic        tick, trigger, finish, pin_rise;

  always_comb begin
    mode     = {i_start_mode_hi, i_start_mode_lo};
    pin_rise = i_ext_convert_start & ~pin_q;
    tick     = (div_cnt_q == div_q);                        // R20
    case (mode)                                             // R09 R18
      START_SW:     trigger = i_busy_write;
      START_TIMER3: trigger = i_timer3_overflow;
      START_PIN:    trigger = pin_rise;
      default:      trigger = i_timer2_overflow;
    endcase
    trigger = trigger & i_conv_enable & (state_q == ST_IDLE); // R01 R22
    finish  = (state_q == ST_CONVERT) & tick & (bit_q == 4'h0);
  end

  // ------------------------------------------------------------------
  // Sequencer
  // ------------------------------------------------------------------
  always_comb begin
    state_d   = state_q;
    div_cnt_d = tick ? 5'h00 : div_cnt_q + 5'h01;           // R07
    trk_cnt_d = trk_cnt_q;
    bit_d     = bit_q;
    code_d    = code_q;
    rhi_d     = rhi_q;
    rlo_d     = rlo_q;
    case (state_q)
      ST_IDLE: begin
        if (trigger) begin
          div_cnt_d = 5'h00;
          trk_cnt_d = 2'h0;
          bit_d     = MSB_INDEX;
          code_d    = 12'h800;
          if (i_track_mode_sel && mode != START_PIN) state_d = ST_TRACK; // R15 R16
          else state_d = ST_CONVERT;
        end
      end
      ST_TRACK: begin
        if (tick) begin
          trk_cnt_d = trk_cnt_q + 2'h1;
          if (trk_cnt_q == TRACK_CLOCKS - 2'h1) state_d = ST_CONVERT; // R15
        end
      end
      ST_CONVERT: begin
        if (tick) begin
          if (!i_cmp_above) code_d[bit_q] = 1'b0;
          if (bit_q != 4'h0) begin
            bit_d         = bit_q - 4'h1;
            code_d[bit_d] = 1'b1;
          end else begin
            state_d = ST_IDLE;
            if (i_left_justify) begin                       // R12
              rhi_d = code_d[11:4];
              rlo_d = {code_d[3:0], 4'h0};
            end else begin
              rhi_d = {4'h0, code_d[11:8]};
              rlo_d = code_d[7:0];
            end
          end
        end
      end
      default: state_d = ST_IDLE;
    endcase
    if (!i_conv_enable) state_d = ST_IDLE;                  // R01
    busy_d = (state_d != ST_IDLE);                          // R10
    done_d = (done_q & ~i_done_clear) | finish;             // R11 R21
    irq_d  = done_d & i_irq_enable;                         // R11
    on_d   = i_conv_enable;                                 // R01
    trk_d  = 1'b0;
    if (i_conv_enable && !i_chip_standby) begin             // R17
      if (!i_track_mode_sel) trk_d = (state_d == ST_IDLE);  // R14
      else if (mode == START_PIN) trk_d = (state_d == ST_IDLE) & ~i_ext_convert_start; // R16
      else trk_d = (state_d == ST_TRACK);                   // R15
    end
  end

  always_ff @(posedge i_clock or negedge i_reset_n) begin
    if (!i_reset_n) begin
      state_q   <= ST_IDLE;
      div_cnt_q <= 5'h00;
      trk_cnt_q <= 2'h0;
      bit_q     <= 4'h0;
      code_q    <= 12'h000;
      pin_q     <= 1'b0;
      busy_q    <= 1'b0;
      done_q    <= 1'b0;
      irq_q     <= 1'b0;
      on_q      <= 1'b0;
      trk_q     <= 1'b0;
      rhi_q     <= 8'h00;
      rlo_q     <= 8'h00;
    end else begin
      state_q   <= state_d;
      div_cnt_q <= div_cnt_d;
      trk_cnt_q <= trk_cnt_d;
      bit_q     <= bit_d;
      code_q    <= code_d;
      pin_q     <= i_ext_convert_start;
      busy_q    <= busy_d;
      done_q    <= done_d;
      irq_q     <= irq_d;
      on_q      <= on_d;
      trk_q     <= trk_d;
      rhi_q     <= rhi_d;
      rlo_q     <= rlo_d;
    end
  end

  // ------------------------------------------------------------------
  // Configuration, frozen while a conversion runs
  // ------------------------------------------------------------------
  always_comb begin
    pair_d = pair_q;
    chan_d = chan_q;
    gain_d = gain_q;
    div_d  = div_q;
    if (state_q == ST_IDLE && !trigger) begin               // R03
      pair_d = i_pair_config;
      chan_d = i_channel_select_field;
      gain_d = i_gain_field;
      div_d  = i_clock_divider_field;
    end
    mux_d  = mux_decode(chan_d, pair_d);                    // R02 R06
    gsel_d = gain_decode(gain_d);                           // R05 R19
  end

  always_ff @(posedge i_clock or negedge i_reset_n) begin
    if (!i_reset_n) begin
      pair_q <= PAIR_CFG_RESET;                             // R04
      chan_q <= CHAN_RESET;
      gain_q <= GAIN_RESET;                                 // R05
      div_q  <= DIVIDER_RESET;
      mux_q  <= '0;
      gsel_q <= GAIN_X1;
    end else begin
      pair_q <= pair_d;
      chan_q <= chan_d;
      gain_q <= gain_d;
      div_q  <= div_d;
      mux_q  <= mux_d;
      gsel_q <= gsel_d;
    end
  end

  always_comb begin
    o_conv_busy      = busy_q;
    o_conv_done_flag = done_q;
    o_irq            = irq_q;
    o_analog_on      = on_q;
    o_track          = trk_q;
    o_trial_code     = code_q;
    o_mux_sel        = mux_q;
    o_gain_sel       = gsel_q;
    o_result_high    = rhi_q;
    o_result_low     = rlo_q;
  end

  // ------------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------------
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!i_reset_n);

  sequence s_busy_fall;
    $past(busy_q) && !busy_q && $past(i_conv_enable);
  endsequence

  sequence s_track_entry;
    state_q == ST_IDLE ##1 state_q == ST_TRACK && div_q == 5'h00;
  endsequence

  sequence s_track_three;
    state_q == ST_TRACK [*3] ##1 state_q == ST_CONVERT;
  endsequence

  chk_done_on_fall: assert property (s_busy_fall |-> done_q) // R11
    else $error("done flag not set at busy fall");
  chk_done_sticky: assert property (done_q && !i_done_clear |=> done_q) // R21
    else $error("done flag dropped without clear");
  chk_busy_start: assert property (trigger |=> busy_q) // R10
    else $error("busy not raised after trigger");
  chk_ignore_busy: assert property (state_q == ST_CONVERT && tick && bit_q != 4'h0 && i_conv_enable // R22
    |=> state_q == ST_CONVERT && bit_q == $past(bit_q) - 4'h1)
    else $error("conversion cut short");
  chk_track_len: assert property (disable iff (!i_reset_n || !i_conv_enable) s_track_entry |-> s_track_three) // R15
    else $error("track period not three clocks");
  chk_disable_idle: assert property (!i_conv_enable |=> state_q == ST_IDLE && !on_q) // R01
    else $error("active while disabled");
  chk_standby_track: assert property (i_chip_standby |=> !trk_q) // R17
    else $error("tracking during standby");
  chk_divider_tick: assert property (tick && state_q != ST_IDLE |=> div_cnt_q == 5'h00) // R20
    else $error("divider did not wrap");
  chk_right_just: assert property (finish && !i_left_justify |=> rhi_q[7:4] == 4'h0) // R12
    else $error("right justified high nibble not zero");

endmodule

`default_nettype wire

// ===== dv/analog_front_model.sv
/*
  Analog front model: comparator answer from a held level.
  Assumes trial code and mux select are registered by the sequencer.
*/
`timescale 1ns/1ps
`default_nettype none
module analog_front_model
  import sar_adc_pkg::*;
(
  input  wire logic [11:0] i_level,
  input  wire logic [11:0] i_trial_code,
  input  wire mux_sel_s    i_mux_sel,
  output logic             o_cmp_above
);
  // Channel folded into level so a wrong route shows
  assign o_cmp_above = (i_level ^ {8'h00, i_mux_sel.pos}) >= i_trial_code;
endmodule
`default_nettype wire

// ===== dv/sar_adc_conversion_sequencer_tb_top.sv
/*
  Self-checking bench for the conversion sequencer.
  Assumes the analog model answers the comparator.
*/
`timescale 1ns/1ps
`default_nettype none
module sar_adc_conversion_sequencer_tb_top
  import sar_adc_pkg::*;
;
  logic        i_clock = 0, i_reset_n = 0, i_conv_enable = 0, i_track_mode_sel = 0;
  logic        i_start_mode_hi = 0, i_start_mode_lo = 0, i_left_justify = 0, i_irq_enable = 0;
  logic        i_busy_write = 0, i_done_clear = 0, i_timer3_overflow = 0, i_timer2_overflow = 0;
  logic        i_ext_convert_start = 0, i_chip_standby = 0, i_cmp_above;
  logic [3:0]  i_pair_config = 0, i_channel_select_field = 0;
  logic [2:0]  i_gain_field = 0;
  logic [4:0]  i_clock_divider_field = 0;
  logic [11:0] level = 0, o_trial_code;
  logic        o_conv_busy, o_conv_done_flag, o_irq, o_analog_on, o_track;
  mux_sel_s    o_mux_sel;
  logic [5:0]  o_gain_sel;
  logic [7:0]  o_result_high, o_result_low;
  logic [5:0]  gain_exp [8] = '{GAIN_X1, GAIN_X2, GAIN_X4, GAIN_X8, GAIN_X16, GAIN_X16, GAIN_HALF, GAIN_HALF};
  int          error_cnt = 0, tests_run = 0;
  bit          hung = 1'b0;
  logic [15:0] exp_q [$];

  always #5 i_clock = ~i_clock;

  sar_adc_conversion_sequencer i_dut (
    .i_clock               (i_clock),
    .i_reset_n             (i_reset_n),
    .i_conv_enable         (i_conv_enable),
    .i_track_mode_sel      (i_track_mode_sel),
    .i_start_mode_hi       (i_start_mode_hi),
    .i_start_mode_lo       (i_start_mode_lo),
    .i_left_justify        (i_left_justify),
    .i_irq_enable          (i_irq_enable),
    .i_busy_write          (i_busy_write),
    .i_done_clear          (i_done_clear),
    .i_pair_config         (i_pair_config),
    .i_channel_select_field(i_channel_select_field),
    .i_gain_field          (i_gain_field),
    .i_clock_divider_field (i_clock_divider_field),
    .i_timer3_overflow     (i_timer3_overflow),
    .i_timer2_overflow     (i_timer2_overflow),
    .i_ext_convert_start   (i_ext_convert_start),
    .i_chip_standby        (i_chip_standby),
    .i_cmp_above           (i_cmp_above),
    .o_conv_busy           (o_conv_busy),
    .o_conv_done_flag      (o_conv_done_flag),
    .o_irq                 (o_irq),
    .o_analog_on           (o_analog_on),
    .o_track               (o_track),
    .o_trial_code          (o_trial_code),
    .o_mux_sel             (o_mux_sel),
    .o_gain_sel            (o_gain_sel),
    .o_result_high         (o_result_high),
    .o_result_low          (o_result_low)
  );
  analog_front_model i_model (.i_level(level), .i_trial_code(o_trial_code), .i_mux_sel(o_mux_sel),
                              .o_cmp_above(i_cmp_above));

  // ------------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------------
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      error_cnt++;
      $display("MISMATCH at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask

  task automatic summarize();
    $display("Checks %0d, mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  task automatic settle();
    repeat (2) @(posedge i_clock);
    #1;
  endtask

  task automatic fire(input int m, input logic v);
    case (m)
      0: i_busy_write <= v;
      1: i_timer3_overflow <= v;
      2: i_ext_convert_start <= v;
      default: i_timer2_overflow <= v;
    endcase
  endtask

  task automatic conv(input int m, d, tm, ch, ie, input logic [11:0] lvl);
    int          n;
    int          k;
    logic [11:0] r;
    if (hung) return;
    // Starts kept at least 10 us apart
    repeat (1000) @(posedge i_clock);
    @(posedge i_clock);
    {i_start_mode_hi, i_start_mode_lo} <= 2'(m);
    i_track_mode_sel <= tm[0];
    i_left_justify <= m[0] ^ tm[0];
    i_irq_enable <= ie[0];
    i_clock_divider_field <= 5'(d);
    i_channel_select_field <= 4'(ch);
    i_pair_config <= 4'h0;
    level <= lvl;
    i_done_clear <= 1'b1;
    fire((m + 1) % 4, 1'b1);
    @(posedge i_clock);
    i_done_clear <= 1'b0;
    fire((m + 1) % 4, 1'b0);
    settle();
    chk(o_conv_busy, 0);
    chk(o_conv_done_flag, 0);
    @(posedge i_clock);
    fire(m, 1'b1);
    @(posedge i_clock);
    fire(m, 1'b0);
    #1;
    for (k = 0; k < 4 && o_conv_busy !== 1'b1; k++) begin
      @(posedge i_clock);
      #1;
    end
    if (o_conv_busy !== 1'b1) begin
      error_cnt++;
      hung = 1'b1;
      return;
    end
    chk(o_track, tm != 0 && m != 2);
    if (tm == 0 || m == 2) chk(o_trial_code, 12'h800);
    n = 0;
    while (o_conv_busy === 1'b1 && n < 2000) begin
      n++;
      @(posedge i_clock);
      fire(m, n == 2);
      #1;
    end
    if (n >= 2000) begin
      error_cnt++;
      hung = 1'b1;
      return;
    end
    chk(n, (12 + ((tm != 0 && m != 2) ? 3 : 0)) * (d + 1));
    chk(o_conv_done_flag, 1);
    r = lvl ^ 12'(ch);
    exp_q.push_back((m[0] ^ tm[0]) ? {r, 4'h0} : {4'h0, r});
    chk({o_result_high, o_result_low}, exp_q.pop_front());
    chk(o_track, tm == 0 || m == 2);
    @(posedge i_clock);
    #1;
    chk(o_irq, ie[0]);
    settle();
    chk(o_conv_busy, 0);
    chk(o_conv_done_flag, 1);
  endtask

  // ------------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------------
  initial begin
    int         c;
    logic [3:0] p;
    logic       df;
    void'($urandom(32'hEF46));
    repeat (4) @(posedge i_clock);
    i_reset_n <= 1'b1;
    i_conv_enable <= 1'b1;
    #1;
    chk(o_gain_sel, GAIN_X1);
    chk(o_mux_sel.diff, 0);
    chk(o_conv_busy, 0);
    for (int g = 0; g < 8; g++) begin
      @(posedge i_clock);
      i_gain_field <= 3'(g);
      settle();
      chk(o_gain_sel, gain_exp[g]);
    end
    for (int i = 0; i < 12; i++) begin
      c = $urandom % 9;
      p = 4'($urandom);
      if (c < 8 && c % 2 == 1) p[c / 2] = 1'b0;
      @(posedge i_clock);
      i_channel_select_field <= 4'(c);
      i_pair_config <= p;
      settle();
      df = c < 8 && p[c / 2];
      chk(o_mux_sel.diff, df);
      chk(o_mux_sel.pos, c);
      if (df || c == 8) chk(o_mux_sel.neg, (c == 8) ? 8 : c + 1);
    end
    @(posedge i_clock);
    i_chip_standby <= 1'b1;
    settle();
    chk(o_track, 0);
    @(posedge i_clock);
    i_chip_standby <= 1'b0;
    settle();
    chk(o_track, 1);
    @(posedge i_clock);
    i_conv_enable <= 1'b0;
    i_busy_write <= 1'b1;
    @(posedge i_clock);
    i_busy_write <= 1'b0;
    settle();
    chk(o_conv_busy, 0);
    chk(o_analog_on, 0);
    @(posedge i_clock);
    i_conv_enable <= 1'b1;
    settle();
    chk(o_analog_on, 1);
    for (int m = 0; m < 4; m++) begin
      for (int tm = 0; tm < 2; tm++) begin
        conv(m, m, tm, m * 2, tm, 12'($urandom));
      end
    end
    conv(0, 31, 1, 8, 1, 12'hFFF);
    conv(3, 0, 0, 7, 0, 12'h000);
    summarize();
  end
endmodule
`default_nettype wire
